// >>> src/wdg_map.vh
/*
 * constants of the watchdog: timing, counter layout, register indexes and
 * field positions.
 * assumes it is included by its bare name from each design file that uses it.
 */
`ifndef WDG_MAP_VH
`define WDG_MAP_VH

// clock rates and derived divider
`define WDG_PCLK_HZ 20000000
`define WDG_OSC_HZ 50000
`define WDG_OSC_DIV (`WDG_PCLK_HZ / `WDG_OSC_HZ)

// counter widths and taps
`define WDG_PRE_W 12
`define WDG_CNT_W 6
`define WDG_SVC_LO 4
`define WDG_TAP_LONG 11
`define WDG_TAP_SHORT 6

// oscillator tick counts
`define WDG_RST_TICKS 32
`define WDG_POR_TICKS 4096

////////////////////////////////////////////////////////////////////////////
// register indexes; byte address is four times the index
`define WDG_ADDR_W 18
`define WDG_IDX_SERVICE 16'hffff
`define WDG_IDX_CONFIG 16'h0001
`define WDG_IDX_CAUSE 16'h0002
`define WDG_IDX_MASK 16'h0003
`define WDG_IDX_STATE 16'h0004

// configuration fields and reset value
`define WDG_CFG_DIS 0
`define WDG_CFG_STOPEN 1
`define WDG_CFG_RATE 2
`define WDG_CFG_W 3
`define WDG_CFG_RST 3'h0

// reset cause fields
`define WDG_ST_WDG 0
`define WDG_ST_ILL 1
`define WDG_ST_W 2

`endif

// >>> src/wdg_sync.v
/*
 * three-stage synchroniser for pin levels; a bit changes once the second
 * and third stages agree.
 * assumes the inputs are asynchronous levels and pclk is free running.
 */
`timescale 1ns/1ns
`default_nettype none

module wdg_sync #(
   parameter W = 2
) (
   // clock and reset
   input  wire         pclk,
   input  wire         presetn,
   // pin side and filtered side
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);

   reg [W-1:0] s1;
   reg [W-1:0] s2;
   reg [W-1:0] s3;
   genvar      i;

   // shift chain; s1 only feeds s2
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1 <= {W{1'b0}};
         s2 <= {W{1'b0}};
         s3 <= {W{1'b0}};
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // accept a bit only when two stages agree, rejecting one-cycle glitches
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         always @(posedge pclk or negedge presetn) begin
            if (!presetn)
               q[i] <= 1'b0;
            else if (s2[i] == s3[i])
               q[i] <= s3[i];
         end
      end
   endgenerate

endmodule

`default_nettype wire

// >>> src/wdg_count.v
/*
 * prescaler and watchdog counter pair, advanced by the oscillator tick.
 * assumes all controls are synchronous to pclk and one cycle wide or level.
 */
`timescale 1ns/1ns
`default_nettype none
`include "wdg_map.vh"

module wdg_count #(
   parameter PW = `WDG_PRE_W,
   parameter CW = `WDG_CNT_W
) (
   // clock and reset
   input  wire          pclk,
   input  wire          presetn,
   // controls
   input  wire          osc_tick,
   input  wire          pre_clr,
   input  wire          svc_clr,
   input  wire          cnt_clr,
   input  wire          rate_short,
   // state
   output reg  [PW-1:0] pre,
   output reg  [CW-1:0] cnt,
   output wire          ovf
);

   wire carry;
   reg  [PW-1:0] next_pre;

   // carry out of the selected prescaler stage clocks the counter
   assign carry = osc_tick & (rate_short ? (&pre[`WDG_TAP_SHORT:0])
                                         : (&pre[`WDG_TAP_LONG:0]));
   assign ovf   = carry & (&cnt);

   // service clears the upper stages only, so up to 15 ticks remain
   always @* begin
      next_pre = osc_tick ? pre + 1'b1 : pre;
      if (svc_clr)
         next_pre[PW-1:`WDG_SVC_LO] = {(PW-`WDG_SVC_LO){1'b0}};
      if (pre_clr)
         next_pre = {PW{1'b0}};
   end

   // free-running counters
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre <= {PW{1'b0}};
         cnt <= {CW{1'b0}};
      end else begin
         pre <= next_pre;
         if (cnt_clr)
            cnt <= {CW{1'b0}};
         else if (carry)
            cnt <= cnt + 1'b1;
      end
   end

endmodule

`default_nettype wire

// >>> src/wdg_top.v
/*
 * watchdog reset counter with apb register access, reset pulse generator,
 * stop and debug gating, and a cause/mask event line.
 * assumes one clock pclk at 20 mhz and that the mode inputs come from
 * logic on pclk; the test voltage detectors are asynchronous pins.
 *
// Operation
// R1 - 6-bit counter fed by 12-bit prescaler
// R2 - unserviced overflow issues asynchronous system reset
// R3 - rate bit selects short or long timeout
// R4 - service write clears counter, prescaler stages 12-5
// R5 - service read returns reset vector low byte
// R6 - reset pin low 32 ticks, sets flag
// R7 - prescaler cleared 4096 ticks after power-up
// R8 - internal reset clears prescaler and counter
// R9 - reset vector fetch clears the prescaler
// R10 - disable bit one turns watchdog off
// R11 - never raises a processor interrupt
// R12 - monitor mode with test voltage disables
// R13 - counters keep running in wait mode
// R14 - stop gates the tick, clears prescaler
// R15 - disabled stop gives illegal opcode reset
// R16 - break with test voltage on reset disables
// R17 - software services after reset and stop
// R18 - counters clocked by internal oscillator tick
// R19 - counter steps on tap carry, gated overflow
 */
`timescale 1ns/1ns
`default_nettype none
`include "wdg_map.vh"

module wdg_top #(
   parameter OSC_DIV   = `WDG_OSC_DIV,
   parameter POR_TICKS = `WDG_POR_TICKS,
   parameter RST_TICKS = `WDG_RST_TICKS
) (
   // apb slave
   input  wire                   pclk,
   input  wire                   presetn,
   input  wire                   psel,
   input  wire                   penable,
   input  wire                   pwrite,
   input  wire [`WDG_ADDR_W-1:0] paddr,
   input  wire [31:0]            pwdata,
   output reg  [31:0]            prdata,
   output reg                    pready,
   output reg                    pslverr,
   // processor state
   input  wire [7:0]             reset_vec_lo,
   input  wire                   vec_fetch,
   input  wire                   other_int_reset,
   input  wire                   wait_mode,
   input  wire                   stop_req,
   input  wire                   stop_exit,
   input  wire                   monitor_mode,
   input  wire                   break_active,
   // test voltage detectors on pins
   input  wire                   tst_on_irq_pin,
   input  wire                   tst_on_rst_pin,
   // reset outputs
   output reg                    rst_pin_o,
   output reg                    rst_pin_oe,
   output reg                    sys_reset,
   output reg                    illegal_reset,
   output reg                    stop_active,
   // event line
   output reg                    event_irq
);

   localparam DW = $clog2(OSC_DIV);
   localparam PCW = 13;
   localparam RCW = 6;

   // one bus word index per register
   // a misaligned byte address hits nothing and is answered with an error
   function hit;
      input [`WDG_ADDR_W-1:0] a;
      input [15:0]            idx;
      begin
         hit = (a[`WDG_ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // declarations

   reg  [DW-1:0]            div;
   reg                      osc_tick;
   wire [1:0]               tst_s;
   reg  [`WDG_CFG_W-1:0]    system_config_one;
   reg  [`WDG_ST_W-1:0]     reset_cause_reg;
   reg  [`WDG_ST_W-1:0]     event_mask;
   reg  [PCW-1:0]           por_cnt;
   reg                      por_done;
   reg                      por_clr;
   reg  [RCW-1:0]           rst_cnt;
   reg                      rst_busy;
   reg                      svc_pulse;
   wire [`WDG_PRE_W-1:0]    pre;
   wire [`WDG_CNT_W-1:0]    cnt;
   wire                     ovf;
   wire                     watchdog_disable;
   wire                     watchdog_rate_select;
   wire                     stop_allowed;
   wire                     wdg_off;
   wire                     wdg_fire;
   wire                     ill_fire;
   wire                     int_reset;
   wire                     tick_gated;
   wire                     setup;
   wire                     wr;
   wire [`WDG_ST_W-1:0]     set_bits;
   reg  [31:0]              next_rdata;
   reg                      next_err;

   ////////////////////////////////////////////////////////////////////////
   // oscillator tick: one pclk pulse per internal_osc_clock period

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div      <= {DW{1'b0}};
         osc_tick <= 1'b0;
      end else if (div == OSC_DIV[DW-1:0] - 1'b1) begin
         div      <= {DW{1'b0}};
         osc_tick <= 1'b1; // see R18
      end else begin
         div      <= div + 1'b1;
         osc_tick <= 1'b0;
      end
   end

   // stop turns the tick off; wait does not touch it
   // wait_mode stays unread on purpose: in wait only interrupt code
   // that services the watchdog keeps the reset away
   assign tick_gated = osc_tick & ~stop_active; // see R14 see R13

   ////////////////////////////////////////////////////////////////////////
   // test voltage pins cross into pclk through three stages and an output flop
   // the pins are slow levels, so the extra flop costs little latency

   wdg_sync #(
      .W (2)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({tst_on_rst_pin, tst_on_irq_pin}),
      .q       (tst_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // configuration fields and disable qualification

   assign watchdog_disable     = system_config_one[`WDG_CFG_DIS];
   assign watchdog_rate_select = system_config_one[`WDG_CFG_RATE];
   assign stop_allowed         = system_config_one[`WDG_CFG_STOPEN];

   // debug and monitor sessions must not be reset by a stalled program
   assign wdg_off = watchdog_disable                    // see R10
                  | (monitor_mode & (tst_s[0] | tst_s[1])) // see R12
                  | (break_active & tst_s[1]);          // see R16

   // overflow is only honoured while enabled and no pulse is running
   // masking during the pulse makes one overflow give exactly one pulse
   assign wdg_fire = ovf & ~wdg_off & ~rst_busy; // see R19 see R2
   assign ill_fire = stop_req & ~stop_allowed & ~stop_active; // see R15

   // any internal reset empties both counters
   // the watchdog's own pulse counts too, so the timeout restarts after it
   assign int_reset = rst_busy | other_int_reset | illegal_reset; // see R8

   ////////////////////////////////////////////////////////////////////////
   // counter pair

   wdg_count #(
      .PW (`WDG_PRE_W),
      .CW (`WDG_CNT_W)
   ) u_count (
      .pclk       (pclk),
      .presetn    (presetn),
      .osc_tick   (tick_gated),
      .pre_clr    (int_reset | por_clr | vec_fetch | stop_active), // see R9
      .svc_clr    (svc_pulse), // see R4
      .cnt_clr    (int_reset | svc_pulse), // see R4 see R8
      .rate_short (watchdog_rate_select), // see R3
      .pre        (pre), // see R1
      .cnt        (cnt),
      .ovf        (ovf)
   );

   ////////////////////////////////////////////////////////////////////////
   // power-up delay: one prescaler clear after the tick count elapses
   // the raw tick is used so a stop cannot stretch the power-up delay

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_cnt  <= {PCW{1'b0}};
         por_done <= 1'b0;
         por_clr  <= 1'b0;
      end else begin
         por_clr <= 1'b0;
         if (!por_done && osc_tick) begin
            if (por_cnt == POR_TICKS[PCW-1:0] - 1'b1) begin
               por_done <= 1'b1;
               por_clr  <= 1'b1; // see R7
            end else begin
               por_cnt <= por_cnt + 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reset pulse: pin driven low for a fixed number of ticks
   // the pin is only ever pulled low; its drive value never leaves zero
   // raw ticks are counted: the pulse itself forces stop to end anyway

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_busy   <= 1'b0;
         rst_cnt    <= {RCW{1'b0}};
         rst_pin_o  <= 1'b0;
         rst_pin_oe <= 1'b0;
         sys_reset  <= 1'b0;
      end else if (wdg_fire) begin
         rst_busy   <= 1'b1;
         rst_cnt    <= {RCW{1'b0}};
         rst_pin_oe <= 1'b1; // see R6
         sys_reset  <= 1'b1; // see R2
      end else if (rst_busy && osc_tick) begin
         if (rst_cnt == RST_TICKS[RCW-1:0] - 1'b1) begin
            rst_busy   <= 1'b0;
            rst_pin_oe <= 1'b0;
            sys_reset  <= 1'b0;
         end else begin
            rst_cnt <= rst_cnt + 1'b1; // see R6
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // stop mode and the illegal stop reset
   // stop never services the watchdog; software must do so around it

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_active   <= 1'b0;
         illegal_reset <= 1'b0;
      end else begin
         illegal_reset <= ill_fire; // see R15
         if (int_reset || stop_exit)
            stop_active <= 1'b0;
         else if (stop_req && stop_allowed)
            stop_active <= 1'b1; // see R14
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb: setup answers in the next cycle, writes land on the access edge
   // zero wait states: pready follows every setup cycle by one clock

   assign setup = psel & ~penable;
   assign wr    = psel & penable & pready & pwrite;

   // read mux and error decode, sampled at the setup edge
   // the service location never shows counter state, only the vector byte
   always @* begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      if (hit(paddr, `WDG_IDX_SERVICE))
         next_rdata[7:0] = reset_vec_lo; // see R5
      else if (hit(paddr, `WDG_IDX_CONFIG))
         next_rdata[`WDG_CFG_W-1:0] = system_config_one;
      else if (hit(paddr, `WDG_IDX_CAUSE))
         next_rdata[`WDG_ST_W-1:0] = reset_cause_reg;
      else if (hit(paddr, `WDG_IDX_MASK))
         next_rdata[`WDG_ST_W-1:0] = event_mask;
      else if (hit(paddr, `WDG_IDX_STATE))
         next_rdata[`WDG_CNT_W-1:0] = cnt;
      else
         next_err = 1'b1;
   end

   // bus answer flops
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup & next_err;
         if (setup && !pwrite)
            prdata <= next_rdata;
         else if (!psel)
            prdata <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // writable registers; any data value services the watchdog
   // a write to the state word is dropped without an error

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         system_config_one <= `WDG_CFG_RST; // see R3
         event_mask        <= {`WDG_ST_W{1'b0}};
         svc_pulse         <= 1'b0;
      end else begin
         svc_pulse <= wr & hit(paddr, `WDG_IDX_SERVICE); // see R4
         if (wr && hit(paddr, `WDG_IDX_CONFIG))
            system_config_one <= pwdata[`WDG_CFG_W-1:0];
         if (wr && hit(paddr, `WDG_IDX_MASK))
            event_mask <= pwdata[`WDG_ST_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reset cause: sticky, write one to clear, a new event beats the clear
   // so a cause landing in the clearing cycle is never lost

   assign set_bits = {ill_fire, wdg_fire};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_cause_reg <= {`WDG_ST_W{1'b0}};
      end else if (wr && hit(paddr, `WDG_IDX_CAUSE)) begin
         reset_cause_reg <= (reset_cause_reg & ~pwdata[`WDG_ST_W-1:0]) | set_bits;
      end else begin
         reset_cause_reg <= reset_cause_reg | set_bits; // see R6
      end
   end

   // system event line for a supervisor; the processor gets no request
   // one cycle of lag is accepted to keep the output on a flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         event_irq <= 1'b0;
      else
         event_irq <= |(reset_cause_reg & event_mask); // see R11
   end

endmodule

`default_nettype wire

// >>> test/wdg_chk_assertions.sv
/* checker for the watchdog: apb handshake, reset pulse, stop and gating.
   assumes it is bound into wdg_top and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module wdg_chk (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // modes and pins
   input wire logic stop_req,
   input wire logic monitor_mode,
   input wire logic break_active,
   input wire logic tst_on_irq_pin,
   input wire logic tst_on_rst_pin,
   // reset outputs
   input wire logic rst_pin_o,
   input wire logic rst_pin_oe,
   input wire logic sys_reset,
   input wire logic illegal_reset,
   input wire logic stop_active
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////
   // the pin is only ever pulled low, never driven high
   pin_low_only_a: assert property (rst_pin_oe |-> !rst_pin_o)
      else $error("reset pin driven high");
   sys_pin_match_a: assert property (sys_reset == rst_pin_oe)
      else $error("system reset and pin drive differ");
   // the bench's 8 ticks of 2 cycles still give 16 cycles, above 8
   reset_hold_a: assert property ($rose(sys_reset) |-> sys_reset [*8])
      else $error("reset pulse too short");
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("no zero wait answer");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   illegal_pulse_a: assert property (illegal_reset |=> !illegal_reset)
      else $error("illegal reset not a pulse");
   stop_entry_a: assert property ($rose(stop_active) |-> $past(stop_req))
      else $error("stop without request");
   // pins pass a synchroniser first, so the gate needs a few cycles
   break_gate_a: assert property ((break_active && tst_on_rst_pin) [*8]
      |-> !$rose(sys_reset))
      else $error("reset during break with test voltage");
   monitor_gate_a: assert property ((monitor_mode && tst_on_irq_pin) [*8]
      |-> !$rose(sys_reset))
      else $error("reset in monitor mode with test voltage");
endmodule
bind wdg_top wdg_chk wdg_chk_i (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
   .stop_req, .monitor_mode, .break_active, .tst_on_irq_pin, .tst_on_rst_pin,
   .rst_pin_o, .rst_pin_oe, .sys_reset, .illegal_reset, .stop_active);
`default_nettype wire

// >>> test/wdg_top_tb_top.sv
/* self-checking bench for wdg_top over apb.
   assumes a shortened tick divider and reset pulse length. */
`timescale 1ns/1ns
`default_nettype none
`include "wdg_map.vh"
module wdg_top_tb_top;
   localparam int OSC = 2;
   localparam int RT = 8;
   localparam int LO = (8192 - 16) * OSC - 8;
   localparam int HI = 8192 * OSC + 8;
   localparam logic [17:0] A_SVC = {`WDG_IDX_SERVICE, 2'b00};
   localparam logic [17:0] A_CFG = {`WDG_IDX_CONFIG, 2'b00};
   localparam logic [17:0] A_CAU = {`WDG_IDX_CAUSE, 2'b00};
   localparam logic [17:0] A_MSK = {`WDG_IDX_MASK, 2'b00};
   localparam logic [17:0] A_BAD = 18'h00040;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  reset_vec_lo;
   logic        vec_fetch, other_int_reset, wait_mode, stop_req, stop_exit;
   logic        monitor_mode, break_active, tst_on_irq_pin, tst_on_rst_pin;
   logic        rst_pin_o, rst_pin_oe, sys_reset, illegal_reset, stop_active;
   logic        event_irq;
   int          n_mismatch = 0;
   int          comparisons = 0;
   int          cyc = 0;

   wdg_top #(.OSC_DIV(OSC), .POR_TICKS(8), .RST_TICKS(RT)) wdg_top_i (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .reset_vec_lo, .vec_fetch, .other_int_reset,
      .wait_mode, .stop_req, .stop_exit, .monitor_mode, .break_active,
      .tst_on_irq_pin, .tst_on_rst_pin, .rst_pin_o, .rst_pin_oe, .sys_reset,
      .illegal_reset, .stop_active, .event_irq);
   ////////////////////////////////////////////////////////////////////////
   // clock, and a ceiling a little above the longest planned run
   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 95000) begin
         n_mismatch++;
         close_out;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   // one apb transfer; ends one edge after release so it may follow itself
   task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1);
      chk(k, 1, "apb answer");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task t_regs;
      apb(0, A_CFG, 0);
      chk(rd, 0, "config reset value");
      apb(0, A_CAU, 0);
      chk(rd, 0, "cause reset value");
      apb(0, A_BAD, 0);
      chk(32'(er), 1, "unmapped error");
      apb(1, A_CFG, 32'h7);
      apb(0, A_CFG, 0);
      chk(rd, 32'h7, "config readback");
      reset_vec_lo <= 8'h5a;
      apb(1, A_SVC, 32'hffffffff);
      apb(0, A_SVC, 0);
      chk(rd, 32'h5a, "service reads vector");
      $display("test regs done");
   endtask

   // service in wait mode keeps reset away, then a short timeout is timed
   task t_service;
      int k;
      wait_mode <= 1'b1;
      apb(1, A_CFG, 32'h4);
      apb(1, A_MSK, 32'h1);
      for (k = 0; k < 4; k++) begin
         apb(1, A_SVC, 32'(k));
         repeat (5000) @(posedge pclk);
      end
      apb(0, A_CAU, 0);
      chk(rd, 0, "serviced, no reset");
      apb(1, A_SVC, 0);
      k = 0;
      while (sys_reset !== 1'b1 && k < 20000) begin
         @(posedge pclk);
         k++;
      end
      chk(32'(k >= LO && k <= HI), 1, "short timeout length");
      chk(32'(rst_pin_oe), 1, "pin pulled");
      chk(32'(rst_pin_o), 0, "pin driven low");
      k = 0;
      while (sys_reset === 1'b1 && k < 100) begin
         @(posedge pclk);
         k++;
      end
      chk(32'(k >= RT * OSC - 2 && k <= RT * OSC + OSC + 2), 1, "pulse width");
      apb(0, A_CAU, 0);
      chk(rd, 32'h1, "watchdog cause");
      chk(32'(event_irq), 1, "event raised");
      apb(1, A_CAU, 32'h1);
      @(posedge pclk);
      chk(32'(event_irq), 0, "event cleared");
      $display("test service done");
   endtask

   task t_stop;
      apb(1, A_CFG, 32'h0);
      stop_req <= 1'b1;
      @(posedge pclk);
      stop_req <= 1'b0;
      @(posedge pclk);
      chk(32'(illegal_reset), 1, "illegal stop");
      apb(0, A_CAU, 0);
      chk(rd, 32'h2, "illegal cause");
      chk(32'(event_irq), 0, "masked cause");
      apb(1, A_CAU, 32'h3);
      apb(1, A_CFG, 32'h2);
      stop_req <= 1'b1;
      @(posedge pclk);
      stop_req <= 1'b0;
      @(posedge pclk);
      chk(32'(stop_active), 1, "stop entered");
      stop_exit <= 1'b1;
      @(posedge pclk);
      stop_exit <= 1'b0;
      @(posedge pclk);
      chk(32'(stop_active), 0, "stop left");
      apb(1, A_CFG, 32'h6);
      repeat (600) @(posedge pclk);
      apb(0, {`WDG_IDX_STATE, 2'b00}, 0);
      chk(32'(rd != 0), 1, "counter running");
      other_int_reset <= 1'b1;
      @(posedge pclk);
      other_int_reset <= 1'b0;
      apb(0, {`WDG_IDX_STATE, 2'b00}, 0);
      chk(rd, 0, "counter cleared");
      vec_fetch <= 1'b1;
      repeat (600) @(posedge pclk);
      apb(0, {`WDG_IDX_STATE, 2'b00}, 0);
      chk(rd, 0, "held by vector fetch");
      vec_fetch <= 1'b0;
      $display("test stop done");
   endtask

   // each gate alone must hold back an overflow that falls in its window
   task t_gate;
      apb(1, A_CFG, 32'h4);
      break_active <= 1'b1;
      tst_on_rst_pin <= 1'b1;
      apb(1, A_SVC, 0);
      repeat (16600) @(posedge pclk);
      apb(0, A_CAU, 0);
      chk(rd, 0, "no reset in break");
      break_active <= 1'b0;
      tst_on_rst_pin <= 1'b0;
      monitor_mode <= 1'b1;
      tst_on_irq_pin <= 1'b1;
      apb(1, A_SVC, 0);
      repeat (16600) @(posedge pclk);
      apb(0, A_CAU, 0);
      chk(rd, 0, "no reset in monitor");
      monitor_mode <= 1'b0;
      tst_on_irq_pin <= 1'b0;
      apb(1, A_CFG, 32'h5);
      apb(1, A_SVC, 0);
      repeat (16600) @(posedge pclk);
      apb(0, A_CAU, 0);
      chk(rd, 0, "no reset when off");
      $display("test gate done");
   endtask

   task close_out;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // main sequence
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, reset_vec_lo} = '0;
      {vec_fetch, other_int_reset, wait_mode, stop_req, stop_exit} = '0;
      {monitor_mode, break_active, tst_on_irq_pin, tst_on_rst_pin} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1, A_SVC, 0);
      t_regs;
      t_service;
      t_stop;
      t_gate;
      close_out;
   end
endmodule
`default_nettype wire
